//--- logic/dmd_decoder.sv
// Data memory space decoder that routes core accesses to storage targets.
`timescale 1ns/1ps
`default_nettype none
module dmd_decoder #(
  parameter int AUX_BYTES = dmd_pkg::DMD_AUX_DEFAULT
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire dmd_pkg::dmd_req_t req_i,
  input wire logic [7:0] psw_i,
  output logic [15:0] code_addr_base_i_unused_o,
  output dmd_pkg::dmd_route_t route_o,
  output logic illegal_o,
  output logic ext_strobes_o
);
  import dmd_pkg::*;

  // ==========================================
  // Local sizes
  // ==========================================
  // Zero fill above the bank field and register number in register mode.
  localparam int REG_FILL = DMD_ADDR_BITS - DMD_BANK_BITS - DMD_REG_SEL_BITS;

  // Zero fill above a byte address inside the wider route address.
  localparam int BYTE_FILL = DMD_ADDR_BITS - DMD_BYTE_BITS;

  // Zero fill above the bit row number when it is added to the bit area base.
  localparam int ROW_FILL = DMD_BYTE_BITS - DMD_BIT_ROW_BITS;

  // Whole internal RAM is the main 256 bytes plus the auxiliary block.
  localparam int IRAM_TOTAL = DMD_MAIN_BYTES + AUX_BYTES;

  // The auxiliary window is what remains of the total once the main bytes are taken.
  // Deriving it this way keeps the external window tied to the RAM that really exists.
  localparam int AUX_LIMIT = IRAM_TOTAL - DMD_MAIN_BYTES;

  // ==========================================
  // Decode helpers
  // ==========================================
  // Extends a byte address into the route address with zeros above it.
  function automatic logic [DMD_ADDR_BITS-1:0] byte_addr(
      input logic [DMD_BYTE_BITS-1:0] b);
    byte_addr = {{BYTE_FILL{1'b0}}, b};
  endfunction

  // Chooses special registers for the upper half and RAM for the lower half.
  // Only direct and bit accesses use this; indirect ones never reach special registers.
  function automatic dmd_tgt_t upper_target(input logic [DMD_BYTE_BITS-1:0] b);
    if (b[DMD_UPPER_MSB]) begin
      upper_target = DMD_TGT_SFR;
    end else begin
      upper_target = DMD_TGT_IRAM;
    end
  endfunction

  // Maps a bit address to the byte that holds the bit.
  // Lower bit addresses fall in the sixteen bytes above the banks; upper ones
  // land on the special registers whose address is a multiple of eight.
  function automatic logic [DMD_BYTE_BITS-1:0] bit_byte(
      input logic [DMD_BYTE_BITS-1:0] b);
    logic [DMD_BIT_ROW_BITS-1:0] row;
    row = b[DMD_BIT_ROW_LSB +: DMD_BIT_ROW_BITS];
    if (b[DMD_UPPER_MSB]) begin
      // Clearing the low bits gives the register at a multiple of eight.
      bit_byte = {b[DMD_BYTE_BITS-1:DMD_BIT_SEL_BITS], {DMD_BIT_SEL_BITS{1'b0}}};
    end else begin
      // Sixteen rows of eight bits above the banks.
      bit_byte = DMD_BIT_BASE + {{ROW_FILL{1'b0}}, row};
    end
  endfunction

  // Forms the RAM byte of a working register from the status word bank field.
  function automatic logic [DMD_ADDR_BITS-1:0] reg_addr(
      input logic [DMD_BYTE_BITS-1:0] processor_status_word,
      input logic [DMD_REG_SEL_BITS-1:0] r);
    // Bank times eight plus register number.
    reg_addr = {{REG_FILL{1'b0}}, processor_status_word[DMD_PSW_BANK_LSB +: DMD_BANK_BITS], r};
  endfunction

  // Adds the index to the base for a table read in program space.
  // The sum wraps at the top of the space, as the core's adder would.
  function automatic logic [DMD_ADDR_BITS-1:0] table_addr(
      input logic [DMD_ADDR_BITS-1:0] base,
      input logic [DMD_BYTE_BITS-1:0] idx);
    table_addr = base + {{BYTE_FILL{1'b0}}, idx};
  endfunction

  // Tells whether an external address lies inside the auxiliary RAM.
  // The compare is done at integer width so a large variant cannot wrap.
  function automatic logic aux_hit(input logic [DMD_ADDR_BITS-1:0] a);
    aux_hit = int'(a) < AUX_LIMIT;
  endfunction

  // ==========================================
  // Combinational decode
  // ==========================================
  dmd_route_t route_next; // Decoded access for the next cycle.
  logic illegal_next; // Refused access: one that reaches no storage, or a write to program space.
  logic [DMD_ADDR_BITS-1:0] code_next; // Program-space table address.

  // Decodes each request to one target; indirect never reaches special registers.
  // Every field starts from a safe value so a new mode cannot leave a latch behind.
  always_comb begin
    route_next = '0;
    illegal_next = 1'b0;
    code_next = '0;
    route_next.valid = req_i.valid;
    route_next.write = req_i.write;
    route_next.wdata = req_i.wdata;
    route_next.addr = req_i.addr;
    case (req_i.mode)
      DMD_MODE_REG: begin
        // Bank from status word plus register number.
        route_next.target = DMD_TGT_IRAM;
        route_next.addr = reg_addr(psw_i, req_i.addr[DMD_REG_SEL_BITS-1:0]);
      end
      DMD_MODE_DIRECT: begin
        // Upper half goes to special registers, lower half to RAM.
        route_next.target = upper_target(req_i.addr[DMD_BYTE_BITS-1:0]);
        route_next.addr = byte_addr(req_i.addr[DMD_BYTE_BITS-1:0]);
      end
      DMD_MODE_INDIRECT: begin
        // Full 256 bytes of RAM, never special registers.
        route_next.target = DMD_TGT_IRAM;
        route_next.addr = byte_addr(req_i.addr[DMD_BYTE_BITS-1:0]);
      end
      DMD_MODE_BIT: begin
        // Single-bit access: the byte that holds the bit and its position.
        route_next.bit_op = 1'b1;
        route_next.bit_sel = req_i.addr[DMD_BIT_SEL_BITS-1:0];
        route_next.target = upper_target(req_i.addr[DMD_BYTE_BITS-1:0]);
        route_next.addr = byte_addr(bit_byte(req_i.addr[DMD_BYTE_BITS-1:0]));
      end
      DMD_MODE_XDATA: begin
        // Only external moves reach the auxiliary RAM; beyond it nothing.
        if (aux_hit(req_i.addr)) begin
          route_next.target = DMD_TGT_AUX;
        end else begin
          // A write here is dropped so no storage changes.
          route_next.target = DMD_TGT_NONE;
          route_next.write = 1'b0;
          illegal_next = req_i.valid;
        end
      end
      DMD_MODE_CODE: begin
        // Table reads add index to base in program space.
        // Program space is never a destination, so a write is refused.
        route_next.write = 1'b0;
        illegal_next = req_i.valid & req_i.write;
        route_next.target = DMD_TGT_CODE;
        code_next = table_addr(req_i.addr, req_i.index);
        route_next.addr = code_next;
      end
      default: begin
        // Unknown modes reach nothing and are flagged.
        route_next.target = DMD_TGT_NONE;
        route_next.write = 1'b0;
        illegal_next = req_i.valid;
      end
    endcase
    // An idle cycle must never carry a write toward storage.
    if (!req_i.valid) begin
      route_next.write = 1'b0;
    end
  end

  // ==========================================
  // Registered outputs
  // ==========================================
  // Routing is registered so every output comes from a flip-flop.
  // The cost is one cycle of latency between request and route.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      route_o <= '0;
    end else begin
      route_o <= route_next;
    end
  end

  // The refusal flag stands for exactly the cycle of the refused route.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      illegal_o <= 1'b0;
    end else begin
      illegal_o <= illegal_next;
    end
  end

  // The table address is zero for every mode but program space, read or refused write.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      code_addr_base_i_unused_o <= '0;
    end else begin
      code_addr_base_i_unused_o <= code_next;
    end
  end

  // ==========================================
  // External bus strobes
  // ==========================================
  // External strobes are never driven; there is no external bus.
  // The output is kept so a pin check can see that it never rises.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_strobes_o <= 1'b0;
    end else begin
      ext_strobes_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- logic/dmd_pkg.sv
// Package with constants and carrier types for the data memory space decoder.
// Notes on behaviour
// - Lowest 32 bytes form four register banks.
// - Status word bits pick the working bank.
// - Next 16 bytes give 128 addressable bits.
// - Bytes 30h to 7fh direct and indirect.
// - Upper 128 RAM bytes indirect access only.
// - Direct upper addresses reach special registers only.
// - Special registers at multiples of 08h bit-addressable.
// - Internal RAM 512, 1024 or 2048 bytes.
// - Auxiliary RAM starts external data space.
// - Auxiliary RAM reached only by external moves.
// - No external memory strobes reach pins.
// - Program and data spaces are separate.
// - Destinations use register, direct or indirect only; the code also passes writes in bit and external-move modes.
// - Table reads add index to base.
package dmd_pkg;
  // Address space limits.
  localparam logic [7:0] DMD_BANK_TOP = 8'h1f;
  localparam logic [7:0] DMD_BIT_BASE = 8'h20;
  localparam logic [7:0] DMD_BIT_TOP = 8'h2f;
  localparam logic [7:0] DMD_UPPER_BASE = 8'h80;
  localparam logic [7:0] DMD_BIT_SFR_BASE = 8'h80;
  localparam int DMD_BANK_BITS = 2;
  localparam int DMD_PSW_BANK_LSB = 3;
  localparam int DMD_AUX_DEFAULT = 1792;
  localparam int DMD_SFR_COUNT = 56;
  localparam logic [7:0] DMD_XDATA_UNDEF = 8'hff;
  // Field widths and positions used by the decode.
  localparam int DMD_REG_SEL_BITS = 3;
  localparam int DMD_BIT_SEL_BITS = 3;
  localparam int DMD_BIT_ROW_LSB = 3;
  localparam int DMD_BIT_ROW_BITS = 4;
  localparam int DMD_UPPER_MSB = 7;
  localparam int DMD_BYTE_BITS = 8;
  localparam int DMD_ADDR_BITS = 16;
  localparam int DMD_MAIN_BYTES = 256;

  // Access modes issued by the core.
  typedef enum logic [2:0] {
    DMD_MODE_REG = 3'b000,
    DMD_MODE_DIRECT = 3'b001,
    DMD_MODE_INDIRECT = 3'b010,
    DMD_MODE_BIT = 3'b011,
    DMD_MODE_XDATA = 3'b100,
    DMD_MODE_CODE = 3'b101
  } dmd_mode_t;

  // Targets that a decoded access may reach.
  typedef enum logic [2:0] {
    DMD_TGT_NONE = 3'b000,
    DMD_TGT_IRAM = 3'b001,
    DMD_TGT_SFR = 3'b010,
    DMD_TGT_AUX = 3'b011,
    DMD_TGT_CODE = 3'b100
  } dmd_tgt_t;

  // One request from the core.
  typedef struct packed {
    logic valid;
    logic write;
    dmd_mode_t mode;
    logic [15:0] addr;
    logic [7:0] index;
    logic [7:0] wdata;
  } dmd_req_t;

  // Decoded routing toward storage.
  typedef struct packed {
    logic valid;
    logic write;
    dmd_tgt_t target;
    logic [15:0] addr;
    logic [2:0] bit_sel;
    logic bit_op;
    logic [7:0] wdata;
  } dmd_route_t;
endpackage

//--- bench/dmd_core_model.sv
// Core-side model that issues data memory requests to the decoder.
`timescale 1ns/1ps
`default_nettype none
module dmd_core_model (
  input wire logic clk_sys_i,
  output var dmd_pkg::dmd_req_t req_o,
  output var logic [7:0] psw_o
);
  import dmd_pkg::*;
  initial {req_o, psw_o} = '0;
  // A request holds until the next call replaces it, as a real core would.
  task automatic issue(dmd_mode_t m, logic [15:0] a, logic w, logic [7:0] p);
    @(posedge clk_sys_i);
    req_o <= '{1'b1, w, m, a, 8'h10, 8'h5a};
    psw_o <= p;
  endtask
endmodule
`default_nettype wire

//--- bench/dmd_checker.sv
// Routing assertions for the data memory space decoder.
`timescale 1ns/1ps
`default_nettype none
module dmd_checker #(parameter int AUX_BYTES = 1792) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire dmd_pkg::dmd_req_t req_i,
  input wire logic [7:0] psw_i,
  input wire logic [15:0] code_addr_base_i_unused_o,
  input wire dmd_pkg::dmd_route_t route_o,
  input wire logic illegal_o,
  input wire logic ext_strobes_o
);
  import dmd_pkg::*;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  // Mode of a live request; idle cycles map to an unused code.
  wire logic [2:0] m = req_i.valid ? req_i.mode : 3'h7;
  dmd_req_t q;
  always_ff @(posedge clk_sys_i) q <= req_i;
  property p_st; !ext_strobes_o; endproperty
  a_st: assert property (p_st) else $error("strobe");
  property p_bk; m == DMD_MODE_REG |=> route_o.addr == {$past(psw_i[4:3]), q.addr[2:0]}; endproperty
  a_bk: assert property (p_bk) else $error("bank");
  property p_dr; m == DMD_MODE_DIRECT |=> route_o.target == (q.addr[7] ? DMD_TGT_SFR : DMD_TGT_IRAM); endproperty
  a_dr: assert property (p_dr) else $error("direct");
  property p_in; m == DMD_MODE_INDIRECT |=> route_o.target == DMD_TGT_IRAM; endproperty
  a_in: assert property (p_in) else $error("indirect");
  property p_bl; m == DMD_MODE_BIT && !req_i.addr[7] |=> route_o.addr == 8'h20 + q.addr[6:3]; endproperty
  a_bl: assert property (p_bl) else $error("bit ram");
  property p_bh; m == DMD_MODE_BIT && req_i.addr[7] |=> route_o.addr == {q.addr[7:3], 3'h0}; endproperty
  a_bh: assert property (p_bh) else $error("bit sfr");
  property p_xd; m == DMD_MODE_XDATA |=> illegal_o == (q.addr >= AUX_BYTES); endproperty
  a_xd: assert property (p_xd) else $error("aux range");
  property p_ax; route_o.target == DMD_TGT_AUX |-> $past(m) == DMD_MODE_XDATA; endproperty
  a_ax: assert property (p_ax) else $error("aux mode");
  property p_cd; m == DMD_MODE_CODE |=> code_addr_base_i_unused_o == q.addr + q.index; endproperty
  a_cd: assert property (p_cd) else $error("table");
  property p_cw; m == DMD_MODE_CODE && req_i.write |=> illegal_o && !route_o.write; endproperty
  a_cw: assert property (p_cw) else $error("code write");
endmodule
bind dmd_decoder dmd_checker #(.AUX_BYTES(AUX_BYTES)) u_chk (.clk_sys_i, .rst_n_i, .req_i,
  .psw_i, .code_addr_base_i_unused_o, .route_o, .illegal_o, .ext_strobes_o);
`default_nettype wire

//--- bench/data_memory_space_decoder_bench.sv
// Self-checking bench for the data memory space decoder.
`timescale 1ns/1ps
`default_nettype none
module data_memory_space_decoder_bench;
  import dmd_pkg::*;
  localparam int AUX = 768; // Smaller variant keeps the range edge cheap to reach.
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0, illegal_o, ext_strobes_o;
  dmd_req_t req_i;
  logic [7:0] psw_i;
  logic [15:0] code_addr_base_i_unused_o;
  dmd_route_t route_o;
  int fails = 0, n_tests = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  dmd_core_model u_core (.clk_sys_i, .req_o(req_i), .psw_o(psw_i));
  dmd_decoder #(.AUX_BYTES(AUX)) u_dut (.clk_sys_i, .rst_n_i, .req_i, .psw_i,
    .code_addr_base_i_unused_o, .route_o, .illegal_o, .ext_strobes_o);
  task automatic test_done();
    if (fails == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(string n, logic [24:0] e, logic [24:0] g);
    n_tests++;
    if (e !== g) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // Refused accesses carry no defined address, so their route address is not judged there.
  task automatic acc(dmd_mode_t m, logic [15:0] a, logic [7:0] p, dmd_tgt_t t,
      logic [15:0] e, logic [2:0] b, logic x);
    u_core.issue(m, a, x, p);
    @(posedge clk_sys_i);
    #1;
    chk("route", {x, 2'h0, t, b, e}, {illegal_o, ext_strobes_o, route_o.write, route_o.target,
      route_o.bit_sel, x ? e : route_o.addr});
    chk("payload", 25'({1'b1, m == DMD_MODE_BIT, 8'h5a}),
      25'({route_o.valid, route_o.bit_op, route_o.wdata}));
  endtask
  task automatic t_code();
    acc(DMD_MODE_CODE, 16'hfff8, 8'h0, DMD_TGT_CODE, 16'h0008, 3'h0, 1'b0);
    chk("table", 25'(16'h0008), 25'(code_addr_base_i_unused_o));
    acc(DMD_MODE_CODE, 16'h0100, 8'h0, DMD_TGT_CODE, 16'h0110, 3'h0, 1'b1);
  endtask
  task automatic t_bank();
    for (int k = 0; k < 4; k++)
      acc(DMD_MODE_REG, 16'h7, 8'he7 | 8'(k << 3), DMD_TGT_IRAM,
        16'(k * 8 + 7), 3'h0, 1'b0);
  endtask
  task automatic t_space();
    logic [7:0] v [4] = '{8'h30, 8'h7f, 8'h80, 8'hff};
    dmd_tgt_t t;
    foreach (v[k]) begin
      t = v[k][7] ? DMD_TGT_SFR : DMD_TGT_IRAM;
      acc(DMD_MODE_DIRECT, 16'(v[k]), 8'h0, t, 16'(v[k]), 3'h0, 1'b0);
      acc(DMD_MODE_INDIRECT, 16'(v[k]), 8'h0, DMD_TGT_IRAM, 16'(v[k]), 3'h0, 1'b0);
      acc(DMD_MODE_BIT, 16'(v[k]), 8'h0, t, v[k][7] ? 16'(v[k] & 8'hf8) : 16'h20 + v[k][6:3],
        v[k][2:0], 1'b0);
    end
  endtask
  task automatic t_aux();
    acc(DMD_MODE_XDATA, 16'h0, 8'h0, DMD_TGT_AUX, 16'h0, 3'h0, 1'b0);
    acc(DMD_MODE_XDATA, 16'(AUX - 1), 8'h0, DMD_TGT_AUX, 16'(AUX - 1), 3'h0, 1'b0);
    acc(DMD_MODE_XDATA, 16'(AUX), 8'h0, DMD_TGT_NONE, 16'h0, 3'h0, 1'b1);
  endtask
  initial begin
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_bank();
    t_space();
    t_aux();
    t_code();
    repeat (2) @(posedge clk_sys_i);
    test_done();
  end
endmodule
`default_nettype wire
